// >>> usc_pkg.sv
// constants and rule notes for the serial status and clock select block
// Functional notes
// - error status clears on reset, power or rx off
// - reading error status clears all its flags
// - parity mismatch at completion sets bit 2
// - missing high stop bit sets bit 1
// - completion with unread buffer sets bit 0
// - receiver checks only first stop bit
// - overrun discards new character, buffer kept
// - parity check only for odd, even modes
// - zero parity mode never flags parity
// - tx status clears on reset, power or tx off
// - buffer full sets on write, clears on move
// - shift busy sets on move, clears when drained
// - buffered next character follows back to back
// - codes zero to ten divide by two power code
// - code eleven takes timer output, above prohibited
// - rewriting same selector value keeps traffic intact
// - mode bit7 power, bit6 tx, bit5 rx enables
// - buffer write starts transfer when transmitter idle
package usc_pkg;
    // register addresses
    localparam logic [15:0] USC_ADDR_MODE = 16'hFF50;
    localparam logic [15:0] USC_ADDR_RXBUF = 16'hFF52;
    localparam logic [15:0] USC_ADDR_RXERR = 16'hFF53;
    localparam logic [15:0] USC_ADDR_TXBUF = 16'hFF54;
    localparam logic [15:0] USC_ADDR_TXSTAT = 16'hFF55;
    localparam logic [15:0] USC_ADDR_CLKSEL = 16'hFF56;
    // reset values
    localparam logic [7:0] USC_RST_MODE = 8'h01;
    localparam logic [7:0] USC_RST_RXBUF = 8'hFF;
    localparam logic [7:0] USC_RST_TXBUF = 8'hFF;
    localparam logic [7:0] USC_RST_RXERR = 8'h00;
    localparam logic [7:0] USC_RST_TXSTAT = 8'h00;
    localparam logic [3:0] USC_RST_CLKSEL = 4'h0;
    // mode register fields
    localparam int USC_MODE_POWER = 7;
    localparam int USC_MODE_TXE = 6;
    localparam int USC_MODE_RXE = 5;
    localparam int USC_MODE_PARH = 4;
    localparam int USC_MODE_PARL = 3;
    localparam int USC_MODE_CL = 2;
    localparam int USC_MODE_SL = 1;
    localparam int USC_MODE_ISRM = 0;
    // status fields
    localparam int USC_ERR_PARITY = 2;
    localparam int USC_ERR_FRAME = 1;
    localparam int USC_ERR_OVERRUN = 0;
    localparam int USC_TX_BUFFULL = 1;
    localparam int USC_TX_BUSY = 0;
    // base clock codes
    localparam logic [3:0] USC_CODE_MAXDIV = 4'hA;
    localparam logic [3:0] USC_CODE_TIMER = 4'hB;
    localparam int USC_PRESC_W = 10;
    // parity modes
    typedef enum logic [1:0] {
        USC_PAR_NONE = 2'b00,
        USC_PAR_ZERO = 2'b01,
        USC_PAR_ODD = 2'b10,
        USC_PAR_EVEN = 2'b11
    } usc_parity_t;
    // transmit path states
    typedef enum logic [1:0] {
        USC_TX_IDLE = 2'b00,
        USC_TX_SHIFT = 2'b01,
        USC_TX_CHAIN = 2'b10
    } usc_tx_state_t;
endpackage

// >>> usc_clk_sel.sv
// base clock selector: power-of-two prescaler or timer edge
`timescale 1ns/1ps
module usc_clk_sel
    import usc_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // control
    input wire logic power_i,
    input wire logic [3:0] code_i,
    input wire logic timer_i,
    // base clock tick
    output logic tick_o
);
    logic [USC_PRESC_W-1:0] cnt_q;
    logic [USC_PRESC_W-1:0] mask;
    logic timer_q;
    logic sel;

    // free running counter; a rewrite of the code never resets it
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !power_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // timer level history for rising edge detect
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            timer_q <= 1'b0;
        end else begin
            timer_q <= timer_i;
        end
    end

    always_comb begin
        mask = USC_PRESC_W'((11'h001 << code_i) - 11'h001);
        if (code_i <= USC_CODE_MAXDIV) begin
            sel = ((cnt_q & mask) == mask);
        end else if (code_i == USC_CODE_TIMER) begin
            sel = timer_i && !timer_q;
        end else begin
            sel = 1'b0;
        end
    end

    // registered tick, held low while the unit is off
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !power_i) begin
            tick_o <= 1'b0;
        end else begin
            tick_o <= sel;
        end
    end
endmodule

// >>> usc_rx_check.sv
// receive completion checks: parity and first stop bit
`timescale 1ns/1ps
module usc_rx_check
    import usc_pkg::*;
(
    // received frame
    input wire logic [7:0] data_i,
    input wire logic parity_bit_i,
    input wire logic stop_bit_i,
    // configuration
    input wire logic [1:0] par_mode_i,
    input wire logic char8_i,
    // verdicts
    output logic parity_err_o,
    output logic frame_err_o
);
    logic ones;

    always_comb begin
        ones = char8_i ? ^data_i : ^data_i[6:0];
        case (usc_parity_t'(par_mode_i))
            USC_PAR_ODD: parity_err_o = !(ones ^ parity_bit_i);
            USC_PAR_EVEN: parity_err_o = ones ^ parity_bit_i;
            default: parity_err_o = 1'b0;
        endcase
    end

    assign frame_err_o = !stop_bit_i;
endmodule

// >>> usc_top.sv
// serial unit status flags, mode register and base clock select
`timescale 1ns/1ps
module usc_top
    import usc_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // cpu register port
    input wire logic [15:0] addr_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [7:0] wr_data_i,
    output logic [7:0] rd_data_o,
    // receive shifter side
    input wire logic rx_done_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_parity_bit_i,
    input wire logic rx_stop_bit_i,
    // transmit shifter side
    input wire logic tx_shift_done_i,
    output logic tx_load_o,
    output logic [7:0] tx_shift_data_o,
    // base clock
    input wire logic timer_channel_output_i,
    output logic serial_base_clock_o,
    // mode outputs
    output logic unit_power_enable_o,
    output logic transmit_enable_o,
    output logic receive_enable_o,
    output logic char8_o,
    output logic two_stop_o
);
    logic [7:0] mode_q;
    logic [3:0] base_clock_code_q;
    logic [7:0] rx_buffer_q;
    logic rx_unread_q;
    logic [2:0] rx_err_q;
    logic [2:0] rx_err_d;
    logic [7:0] tx_buffer_q;
    logic tx_buffer_full_flag_q;
    logic tx_shift_busy_flag_q;
    logic tx_buffer_full_flag_d;
    logic tx_shift_busy_flag_d;
    usc_tx_state_t tx_state_q;
    usc_tx_state_t tx_state_d;
    logic tx_move;
    logic power;
    logic tx_on;
    logic rx_on;
    logic wr_mode;
    logic wr_txbuf;
    logic wr_clksel;
    logic rd_rxerr;
    logic rd_rxbuf;
    logic parity_err;
    logic frame_err;
    logic overrun;
    logic tick;
    logic [7:0] rd_mux;

    // unit enables from the mode register
    assign power = mode_q[USC_MODE_POWER];
    assign tx_on = power && mode_q[USC_MODE_TXE];
    assign rx_on = power && mode_q[USC_MODE_RXE];

    // address decode; status registers take no write strobe at all
    assign wr_mode = wr_en_i && (addr_i == USC_ADDR_MODE);
    assign wr_txbuf = wr_en_i && (addr_i == USC_ADDR_TXBUF);
    assign wr_clksel = wr_en_i && (addr_i == USC_ADDR_CLKSEL);
    assign rd_rxerr = rd_en_i && (addr_i == USC_ADDR_RXERR);
    assign rd_rxbuf = rd_en_i && (addr_i == USC_ADDR_RXBUF);

    // mode register
    // enable bits
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            mode_q <= USC_RST_MODE;
        end else if (wr_mode) begin
            mode_q <= wr_data_i;
        end
    end

    // clock selection register, upper nibble reads zero
    // same value harmless
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            base_clock_code_q <= USC_RST_CLKSEL;
        end else if (wr_clksel) begin
            base_clock_code_q <= wr_data_i[3:0];
        end
    end

    // base clock generation
    usc_clk_sel u_clk_sel (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .power_i(power),
        .code_i(base_clock_code_q),
        .timer_i(timer_channel_output_i),
        .tick_o(tick)
    );

    // frame checks on the completed character
    usc_rx_check u_rx_check (
        .data_i(rx_data_i),
        .parity_bit_i(rx_parity_bit_i),
        .stop_bit_i(rx_stop_bit_i),
        .par_mode_i(mode_q[USC_MODE_PARH:USC_MODE_PARL]),
        .char8_i(mode_q[USC_MODE_CL]),
        .parity_err_o(parity_err),
        .frame_err_o(frame_err)
    );

    // a completion while the last character is unread is an overrun
    // overrun detect
    assign overrun = rx_done_i && rx_on && rx_unread_q && !rd_rxbuf;

    // error flags: new errors win over the clear from a read
    always_comb begin
        rx_err_d = rx_err_q;
        if (rd_rxerr) begin
            rx_err_d = 3'h0;
        end
        if (rx_done_i && rx_on) begin
            rx_err_d[USC_ERR_PARITY] = rx_err_d[USC_ERR_PARITY] | parity_err;
            rx_err_d[USC_ERR_FRAME] = rx_err_d[USC_ERR_FRAME] | frame_err;
            rx_err_d[USC_ERR_OVERRUN] = rx_err_d[USC_ERR_OVERRUN] | overrun;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !rx_on) begin
            rx_err_q <= USC_RST_RXERR[2:0];
        end else begin
            rx_err_q <= rx_err_d;
        end
    end

    // receive buffer; power off returns it to its reset value
    // discard on overrun
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !power) begin
            rx_buffer_q <= USC_RST_RXBUF;
        end else if (rx_done_i && rx_on && !overrun) begin
            rx_buffer_q <= rx_data_i;
        end
    end

    // unread marker: set by a stored character, cleared by a buffer read
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !rx_on) begin
            rx_unread_q <= 1'b0;
        end else if (rx_done_i && !overrun) begin
            rx_unread_q <= 1'b1;
        end else if (rd_rxbuf) begin
            rx_unread_q <= 1'b0;
        end
    end

    // transmit buffer data
    // write starts transfer
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tx_buffer_q <= USC_RST_TXBUF;
        end else if (wr_txbuf) begin
            tx_buffer_q <= wr_data_i;
        end
    end

    // move buffer to shifter when idle, or at the end of a frame
    // back to back
    assign tx_move = tx_buffer_full_flag_q &&
                     (!tx_shift_busy_flag_q || tx_shift_done_i);

    // transmit state and flags
    always_comb begin
        tx_state_d = tx_state_q;
        tx_buffer_full_flag_d = tx_buffer_full_flag_q;
        tx_shift_busy_flag_d = tx_shift_busy_flag_q;
        if (tx_move) begin
            tx_buffer_full_flag_d = 1'b0;
            tx_shift_busy_flag_d = 1'b1;
            tx_state_d = USC_TX_SHIFT;
        end else if (tx_shift_done_i && tx_shift_busy_flag_q) begin
            tx_shift_busy_flag_d = 1'b0;
            tx_state_d = USC_TX_IDLE;
        end
        if (wr_txbuf) begin
            tx_buffer_full_flag_d = 1'b1;
        end
        if (tx_shift_busy_flag_d && tx_buffer_full_flag_d) begin
            tx_state_d = USC_TX_CHAIN;
        end
        case (tx_state_d)
            USC_TX_IDLE: tx_state_d = USC_TX_IDLE;
            USC_TX_SHIFT: tx_state_d = USC_TX_SHIFT;
            USC_TX_CHAIN: tx_state_d = USC_TX_CHAIN;
            default: tx_state_d = USC_TX_IDLE;
        endcase
    end

    // transmit path state; a disabled transmitter always restarts idle
    // clear on disable
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !tx_on) begin
            tx_state_q <= USC_TX_IDLE;
        end else begin
            tx_state_q <= tx_state_d;
        end
    end

    // buffer full flag; a disabled transmitter forgets buffered data
    // full flag clear
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !tx_on) begin
            tx_buffer_full_flag_q <= 1'b0;
        end else begin
            tx_buffer_full_flag_q <= tx_buffer_full_flag_d;
        end
    end

    // shift busy flag; cleared with the enable so a reinit starts clean
    // software must see it low before reinit, or a frame is cut short
    // busy flag clear
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !tx_on) begin
            tx_shift_busy_flag_q <= 1'b0;
        end else begin
            tx_shift_busy_flag_q <= tx_shift_busy_flag_d;
        end
    end

    // load pulse towards the shift register, one cycle per move
    // the pulse is registered, so the shifter sees data and pulse together
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !tx_on) begin
            tx_load_o <= 1'b0;
        end else begin
            tx_load_o <= tx_move;
        end
    end

    // shifter data, held between loads so the shifter may sample late
    // a write while full overwrites the buffer, never this copy
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !tx_on) begin
            tx_shift_data_o <= USC_RST_TXBUF;
        end else if (tx_move) begin
            tx_shift_data_o <= tx_buffer_q;
        end
    end

    // read multiplexer; unmapped addresses read zero
    // status registers have no write path, so they only ever read
    // status write ignored
    always_comb begin
        rd_mux = 8'h00;
        case (addr_i)
            USC_ADDR_MODE: rd_mux = mode_q;
            USC_ADDR_RXBUF: rd_mux = rx_buffer_q;
            USC_ADDR_RXERR: rd_mux = {5'h00, rx_err_q};
            USC_ADDR_TXBUF: rd_mux = tx_buffer_q;
            USC_ADDR_TXSTAT: rd_mux = {6'h00, tx_buffer_full_flag_q, tx_shift_busy_flag_q};
            USC_ADDR_CLKSEL: rd_mux = {4'h0, base_clock_code_q};
            default: rd_mux = 8'h00;
        endcase
    end

    // registered read data, zero in cycles without a read strobe
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !rd_en_i) begin
            rd_data_o <= 8'h00;
        end else begin
            rd_data_o <= rd_mux;
        end
    end

    // base clock tick towards the baud divider, one cycle late
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            serial_base_clock_o <= 1'b0;
        end else begin
            serial_base_clock_o <= tick;
        end
    end

    // unit power level for the shifters
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            unit_power_enable_o <= 1'b0;
        end else begin
            unit_power_enable_o <= power;
        end
    end

    // transmit enable, only ever high while the unit is powered
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            transmit_enable_o <= 1'b0;
        end else begin
            transmit_enable_o <= tx_on;
        end
    end

    // receive enable, only ever high while the unit is powered
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            receive_enable_o <= 1'b0;
        end else begin
            receive_enable_o <= rx_on;
        end
    end

    // character length for both shifters
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            char8_o <= 1'b0;
        end else begin
            char8_o <= mode_q[USC_MODE_CL];
        end
    end

    // stop bit count, used by the transmitter only
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            two_stop_o <= 1'b0;
        end else begin
            two_stop_o <= mode_q[USC_MODE_SL];
        end
    end
endmodule

// >>> usc_far_node.sv
// far-side shifter model: ends each frame a set number of cycles after load
`timescale 1ns/1ps
module usc_far_node (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // shifter handshake
    input wire logic load_i,
    input wire logic [7:0] delay_i,
    output logic done_o
);
    logic busy_q;
    logic [7:0] cnt_q;
    // frame timer, one-cycle done pulse at its end
    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        if (sys_rst_i) begin
            busy_q <= 1'b0;
            cnt_q <= 8'h00;
        end else if (load_i) begin
            busy_q <= 1'b1;
            cnt_q <= delay_i;
        end else if (busy_q && cnt_q == 8'h00) begin
            busy_q <= 1'b0;
            done_o <= 1'b1;
        end else if (busy_q) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule

// >>> usc_top_sva.sv
// port assertions for the serial status and clock select block
`timescale 1ns/1ps
module usc_top_sva
    import usc_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // register port
    input wire logic [15:0] addr_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [7:0] rd_data_o,
    // transmit, clock and mode outputs
    input wire logic tx_load_o,
    input wire logic [7:0] tx_shift_data_o,
    input wire logic serial_base_clock_o,
    input wire logic unit_power_enable_o,
    input wire logic transmit_enable_o,
    input wire logic receive_enable_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    // read data only after a read
    rd_idle_a: assert property (!$past(rd_en_i) |-> rd_data_o == 8'h00)
        else $error("read data without read");
    err_hi_a: assert property (rd_en_i && addr_i == USC_ADDR_RXERR |=>
        rd_data_o[7:3] == 5'h00) else $error("error status high bits set");
    stat_hi_a: assert property (rd_en_i && addr_i == USC_ADDR_TXSTAT |=>
        rd_data_o[7:2] == 6'h00) else $error("tx status high bits set");
    mode_wr_a: assert property (wr_en_i && addr_i == USC_ADDR_MODE ##1
        !(wr_en_i && addr_i == USC_ADDR_MODE) |=>
        unit_power_enable_o == $past(wr_data_i[7], 2)
        && transmit_enable_o == ($past(wr_data_i[7], 2) & $past(wr_data_i[6], 2))
        && receive_enable_o == ($past(wr_data_i[7], 2) & $past(wr_data_i[5], 2)))
        else $error("mode enables wrong");
    en_pwr_a: assert property (transmit_enable_o || receive_enable_o |->
        unit_power_enable_o) else $error("enable without power");
    load_en_a: assert property (tx_load_o |-> transmit_enable_o)
        else $error("load while transmit off");
    load_one_a: assert property (tx_load_o |=> !tx_load_o)
        else $error("load pulse too long");
    // no base tick while powered off
    clk_off_a: assert property (!unit_power_enable_o [*3] |-> !serial_base_clock_o)
        else $error("base tick while off");
    // outputs at reset values after reset
    rst_out_a: assert property ($past(sys_rst_i) |-> !tx_load_o && !serial_base_clock_o
        && tx_shift_data_o == 8'hFF && !unit_power_enable_o) else $error("reset values wrong");
endmodule
bind usc_top usc_top_sva sva (.clk_i, .sys_rst_i, .addr_i, .wr_en_i, .rd_en_i, .wr_data_i,
    .rd_data_o, .tx_load_o, .tx_shift_data_o, .serial_base_clock_o, .unit_power_enable_o,
    .transmit_enable_o, .receive_enable_o);

// >>> usc_top_tb.sv
// self-checking bench for the serial status and clock select block
`timescale 1ns/1ps
module usc_top_tb
    import usc_pkg::*;
;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, wr_en_i = 1'b0, rd_en_i = 1'b0;
    logic rx_done_i = 1'b0, rx_parity_bit_i = 1'b0, rx_stop_bit_i = 1'b1;
    logic timer_channel_output_i = 1'b0, tmr_run = 1'b0, prev_done = 1'b0;
    logic tx_shift_done_i, tx_load_o, serial_base_clock_o, unit_power_enable_o;
    logic transmit_enable_o, receive_enable_o, char8_o, two_stop_o;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0] wr_data_i = 8'h00, rx_data_i = 8'h00, delay = 8'h28, v;
    logic [7:0] rd_data_o, tx_shift_data_o;
    int mismatches = 0, n_compared = 0, n_tick = 0, n_rise = 0;
    always #12.5 clk_i = ~clk_i;
    usc_top uut (.clk_i, .sys_rst_i, .addr_i, .wr_en_i, .rd_en_i, .wr_data_i, .rd_data_o,
        .rx_done_i, .rx_data_i, .rx_parity_bit_i, .rx_stop_bit_i, .tx_shift_done_i,
        .tx_load_o, .tx_shift_data_o, .timer_channel_output_i, .serial_base_clock_o,
        .unit_power_enable_o, .transmit_enable_o, .receive_enable_o, .char8_o, .two_stop_o);
    usc_far_node far (.clk_i, .sys_rst_i, .load_i(tx_load_o), .delay_i(delay),
        .done_o(tx_shift_done_i));
    // tick and timer edge counts, random timer waveform
    always @(posedge clk_i) begin
        prev_done <= tx_shift_done_i;
        if (serial_base_clock_o) n_tick <= n_tick + 1;
        if (tmr_run && $urandom % 3 == 0) begin
            timer_channel_output_i <= ~timer_channel_output_i;
            if (!timer_channel_output_i) n_rise <= n_rise + 1;
        end
    end
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic hang(input bit hit);
        if (hit) begin
            mismatches++;
            close_out();
        end
    endtask
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_en_i <= 1'b1;
        addr_i <= a;
        wr_data_i <= d;
        @(posedge clk_i);
        wr_en_i <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_en_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_en_i <= 1'b0;
        #1 d = rd_data_o;
    endtask
    task automatic rchk(input string nm, input logic [15:0] a, input logic [7:0] e);
        rd(a, v);
        chk(nm, v, e);
    endtask
    task automatic rxf(input logic [7:0] d, input logic p, input logic s);
        @(posedge clk_i);
        rx_done_i <= 1'b1;
        rx_data_i <= d;
        rx_parity_bit_i <= p;
        rx_stop_bit_i <= s;
        @(posedge clk_i);
        rx_done_i <= 1'b0;
        rx_data_i <= ~d;
        rx_parity_bit_i <= ~p;
    endtask
    // expected error flags: parity judged only in odd and even modes
    function automatic logic [7:0] exp_err(logic [1:0] pm, logic [7:0] d, logic p, logic s);
        logic ones;
        ones = ^d ^ p;
        exp_err = {5'h00, pm[1] & (ones ^ ~pm[0]), ~s, 1'b0};
    endfunction
    task automatic period(output int p);
        int n;
        p = 0;
        for (n = 0; n < 2100 && serial_base_clock_o !== 1'b1; n++) @(posedge clk_i) #1;
        do begin
            @(posedge clk_i) #1;
            p++;
        end while (serial_base_clock_o !== 1'b1 && p < 2100);
        hang(p == 2100);
    endtask
    initial begin
        int i, p, k;
        logic [1:0] pm;
        logic c8;
        logic [7:0] d;
        logic [7:0] md;
        v = 8'($urandom(32'h07A53798));
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rchk("err_rst", USC_ADDR_RXERR, 8'h00);
        rchk("stat_rst", USC_ADDR_TXSTAT, 8'h00);
        rchk("sel_rst", USC_ADDR_CLKSEL, 8'h00);
        rchk("unmapped", 16'hFF51, 8'h00);
        $display("reset test done");
        for (i = 0; i < 16; i++) begin
            pm = i[1:0];
            c8 = 1'($urandom);
            d = 8'($urandom) & {c8, 7'h7F};
            wr(USC_ADDR_MODE, 8'h80);
            md = {3'b101, pm, c8, 1'($urandom), 1'b0};
            wr(USC_ADDR_MODE, md);
            rxf(d, i[2], i[3]);
            v = {unit_power_enable_o, transmit_enable_o, receive_enable_o, 2'h0,
                char8_o, two_stop_o, 1'b0};
            chk("mode_out", v, md & 8'hE6);
            rchk("mode_rd", USC_ADDR_MODE, md);
            rchk("err_flags", USC_ADDR_RXERR, exp_err(pm, d, i[2], i[3]));
            rchk("err_clear", USC_ADDR_RXERR, 8'h00);
            rchk("rx_buf", USC_ADDR_RXBUF, d);
        end
        wr(USC_ADDR_MODE, 8'hA4);
        rxf(8'h5A, 1'b0, 1'b1);
        rxf(8'hA5, 1'b0, 1'b1);
        // a write to the error status must not set flags
        wr(USC_ADDR_RXERR, 8'hFF);
        rchk("overrun", USC_ADDR_RXERR, 8'h01);
        rchk("rx_keep", USC_ADDR_RXBUF, 8'h5A);
        rxf(8'h11, 1'b0, 1'b0);
        wr(USC_ADDR_MODE, 8'h80);
        rchk("rx_off", USC_ADDR_RXERR, 8'h00);
        $display("receive test done");
        wr(USC_ADDR_MODE, 8'hC0);
        d = 8'($urandom);
        wr(USC_ADDR_TXBUF, d);
        wr(USC_ADDR_TXSTAT, 8'hFF);
        rchk("tx_busy", USC_ADDR_TXSTAT, 8'h01);
        chk("tx_data", tx_shift_data_o, d);
        // second byte after full flag seen low
        wr(USC_ADDR_TXBUF, ~d);
        rchk("tx_full", USC_ADDR_TXSTAT, 8'h03);
        for (k = 0; k < 100 && tx_load_o !== 1'b1; k++) @(posedge clk_i) #1;
        hang(k == 100);
        chk("chain_gap", {7'h00, prev_done}, 8'h01);
        chk("tx_data2", tx_shift_data_o, ~d);
        rchk("tx_busy2", USC_ADDR_TXSTAT, 8'h01);
        // wait for the shifter to drain
        for (k = 0; k < 100 && v !== 8'h00; k++) rd(USC_ADDR_TXSTAT, v);
        hang(k == 100);
        chk("tx_idle", v, 8'h00);
        // transmit disable clears status, prompt far side
        delay = 8'h02;
        wr(USC_ADDR_TXBUF, d);
        wr(USC_ADDR_MODE, 8'h80);
        rchk("tx_off", USC_ADDR_TXSTAT, 8'h00);
        $display("transmit test done");
        for (i = 0; i <= 10; i++) begin
            wr(USC_ADDR_MODE, 8'h00);
            wr(USC_ADDR_CLKSEL, 8'(i));
            wr(USC_ADDR_MODE, 8'h80);
            period(p);
            chk("div", 8'(p == (1 << i)), 8'h01);
            p = n_tick;
            wr(USC_ADDR_CLKSEL, 8'(i));
            repeat ((4 << i) - 2) @(posedge clk_i);
            #1 chk("div_same", 8'(n_tick - p), 8'h04);
        end
        // timer rising edges become base ticks
        wr(USC_ADDR_MODE, 8'h00);
        wr(USC_ADDR_CLKSEL, 8'h0B);
        wr(USC_ADDR_MODE, 8'h80);
        repeat (4) @(posedge clk_i);
        #1 p = n_tick;
        k = n_rise;
        tmr_run <= 1'b1;
        repeat (80) @(posedge clk_i);
        tmr_run <= 1'b0;
        repeat (6) @(posedge clk_i);
        #1 chk("tmr_ticks", 8'(n_tick - p), 8'(n_rise - k));
        // prohibited codes give no base tick
        for (i = 12; i < 16; i++) begin
            wr(USC_ADDR_MODE, 8'h00);
            wr(USC_ADDR_CLKSEL, 8'(i));
            wr(USC_ADDR_MODE, 8'h80);
            #1 p = n_tick;
            repeat (40) @(posedge clk_i);
            #1 chk("no_tick", 8'(n_tick - p), 8'h00);
        end
        $display("clock test done");
        close_out();
    end
endmodule
